//--- hdl/ecd_pkg.sv
// Purpose: Shared constants for the engine control command decoder.
// Assumes: Commands arrive as 32-bit dwords, header first.
// Notes: Field positions refer to the header dword unless named otherwise.
package ecd_pkg;
   localparam int ECD_MAX_DW = 4;
   localparam int ECD_LEN_W = 9;
   localparam logic [2:0] ECD_TYPE_CONTROL = 3'h0;
   localparam logic [5:0] ECD_OP_NOOP = 6'h00;
   localparam logic [5:0] ECD_OP_HEAD_REPORT = 6'h07;
   localparam logic [5:0] ECD_OP_MAILBOX_SYNC = 6'h16;
   localparam logic [5:0] ECD_OP_REG_LOAD = 6'h22;
   localparam logic [5:0] ECD_OP_STORE_REG = 6'h24;
   localparam logic [5:0] ECD_OP_STORE_IMM = 6'h20;
   localparam logic [5:0] ECD_OP_FLUSH = 6'h26;
   localparam logic [5:0] ECD_OP_BATCH_START = 6'h31;
   localparam int ECD_TYPE_HI = 31;
   localparam int ECD_TYPE_LO = 29;
   localparam int ECD_OP_HI = 28;
   localparam int ECD_OP_LO = 23;
   localparam int ECD_FL_STATUS_IDX = 21;
   localparam int ECD_FL_TLB_INV = 18;
   localparam int ECD_FL_TAG_SYNC = 17;
   localparam int ECD_FL_POST_HI = 15;
   localparam int ECD_FL_POST_LO = 14;
   localparam int ECD_FL_NOTIFY = 8;
   localparam int ECD_FL_ADDR_GLOBAL = 2;
   localparam int ECD_NOOP_ID_EN = 22;
   localparam int ECD_NOOP_ID_W = 22;
   localparam int ECD_LRI_BWD_HI = 11;
   localparam int ECD_LRI_BWD_LO = 8;
   localparam int ECD_MBOX_UPDATE = 21;
   localparam int ECD_MBOX_COMPARE = 20;
   localparam logic [1:0] ECD_POST_NONE = 2'h0;
   localparam logic [1:0] ECD_POST_IMM = 2'h1;
   localparam logic [1:0] ECD_POST_RSVD = 2'h2;
   localparam logic [1:0] ECD_POST_TIME = 2'h3;
   localparam logic [3:0] ECD_BWD_NONE = 4'hF;
   localparam logic [3:0] ECD_BWD_ALL = 4'h0;
   localparam logic [ECD_NOOP_ID_W-1:0] ECD_NOOP_ID_RST = 22'h000000;

   // Total dwords of a command: length field plus two for biased commands.
   function automatic logic [ECD_LEN_W-1:0] ecdCmdLength(input logic [31:0] hdr);
      logic [5:0] op;
      logic [ECD_LEN_W-1:0] len;
      op = hdr[ECD_OP_HI:ECD_OP_LO];
      len = 9'h001;
      if (hdr[ECD_TYPE_HI:ECD_TYPE_LO] == ECD_TYPE_CONTROL) begin
         if (op == ECD_OP_FLUSH) begin
            len = {3'h0, hdr[5:0]} + 9'h002;
         end else if (op == ECD_OP_REG_LOAD || op == ECD_OP_MAILBOX_SYNC || op == ECD_OP_STORE_REG ||
                      op == ECD_OP_STORE_IMM || op == ECD_OP_BATCH_START) begin
            len = {1'b0, hdr[7:0]} + 9'h002;
         end
      end
      return len;
   endfunction
endpackage

//--- hdl/ecd_pkt_if.sv
// Purpose: Carries one gathered command packet from the gatherer to the executor.
// Assumes: One packet in flight; taken is a one-cycle pulse.
// Notes: Dwords beyond the buffer depth are not carried.
interface ecd_pkt_if #(parameter int MAX_DW = 4);
   logic valid;
   logic taken;
   logic [31:0] dw [MAX_DW];
   modport src (output valid, output dw, input taken);
   modport dst (input valid, input dw, output taken);
endinterface

//--- hdl/ecd_dword_gatherer.sv
// Purpose: Collects the dwords of one command into a packet buffer.
// Assumes: The stream presents dwords with valid and ready.
// Notes: Extra dwords of long commands are consumed and dropped.
module ecd_dword_gatherer
   import ecd_pkg::*;
#(
   parameter int MAX_DW = ECD_MAX_DW
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   input wire logic [31:0] inData,
   output logic inReady_q,
   ecd_pkt_if.src pkt
);
   logic [ECD_LEN_W-1:0] idx_q;
   logic [ECD_LEN_W-1:0] need_q;
   logic [ECD_LEN_W-1:0] needNow;
   logic accept;
   logic last;
   logic [31:0] buf_q [MAX_DW];

   // The header dword sets how many dwords belong to the packet.
   assign accept = inValid && inReady_q;
   assign needNow = (idx_q == 9'h000) ? ecdCmdLength(inData) : need_q;
   assign last = (idx_q + 9'h001) == needNow;

   // Counts dwords and hands the packet over when the last one lands.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idx_q <= 9'h000;
         need_q <= 9'h001;
         inReady_q <= 1'b0;
         pkt.valid <= 1'b0;
      end else begin
         if (pkt.taken) begin
            pkt.valid <= 1'b0;
            inReady_q <= 1'b1;
         end else if (accept && last) begin
            pkt.valid <= 1'b1;
            inReady_q <= 1'b0;
            idx_q <= 9'h000;
         end else begin
            inReady_q <= !pkt.valid;
            if (accept) begin
               idx_q <= idx_q + 9'h001;
            end
         end
         if (accept && idx_q == 9'h000) begin
            need_q <= needNow;
         end
      end
   end

   // Stores dwords that fit in the buffer.
   always_ff @(posedge clk) begin
      for (int i = 0; i < MAX_DW; i++) begin
         if (!rst_n) begin
            buf_q[i] <= 32'h00000000;
         end else if (accept && idx_q == i[ECD_LEN_W-1:0]) begin
            buf_q[i] <= inData;
         end
      end
   end

   assign pkt.dw = buf_q;
endmodule

//--- hdl/ecd_cmd_decoder.sv
// Purpose: Decodes and executes flush, register load, no-op, head report and mailbox commands.
// Assumes: Memory writes are held until memWrAck; register writes are single-cycle pulses.
// Notes: Unknown commands are consumed and flagged with badCmd.
// Functional notes
// - Status-index flush addresses the status page
// - Non-secure batch with per-process uses private page
// - Invalidate bit honoured only for post-sync 1h/3h
// - Clear invalidation mode invalidates every flush
// - Tagged sync clears tagged lines after flush
// - Post-sync 3 writes elapsed time, upper zero
// - Destination bit picks per-process or global translation
// - Notify raises maskable completion interrupt after write
// - Immediate data used only for immediate write
// - Byte disables 1111 suppress, 0000 write whole
// - Register load writes data to dword offset
// - Head report writes ring head pointer
// - Opcode 16h decodes as mailbox semaphore
// - Opcode 26h control type decodes as flush
// - Flush stalls until drawing engines are idle
module ecd_cmd_decoder
   import ecd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire logic [31:0] cmdData,
   output logic cmdReady,
   input wire logic inBatch,
   input wire logic batchNonSecure,
   input wire logic perProcessEnable,
   input wire logic flushTlbModeSel,
   input wire logic syncIrqMask,
   input wire logic enginesIdle,
   input wire logic [31:0] elapsedTime,
   input wire logic [31:0] ringHead,
   input wire logic [31:0] headReportAddr,
   output logic memWrValid_q,
   input wire logic memWrAck,
   output logic [31:0] memWrAddr_q,
   output logic [63:0] memWrData_q,
   output logic memWrQword_q,
   output logic memWrGlobal_q,
   output logic memWrStatusIdx_q,
   output logic memWrPerProcPage_q,
   output logic regWrValid_q,
   output logic [31:0] regWrAddr_q,
   output logic [31:0] regWrData_q,
   output logic [3:0] regWrByteEn_q,
   output logic [ECD_NOOP_ID_W-1:0] noopId_q,
   output logic mboxValid_q,
   output logic mboxSignal_q,
   output logic mboxWait_q,
   output logic tlbInvalidate_q,
   output logic taggedClear_q,
   output logic syncIrq_q,
   output logic badCmd_q
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_DRAIN = 4'b0010,
      S_MEMWR = 4'b0100,
      S_POST = 4'b1000
   } ecd_state_t;

   ecd_pkt_if #(.MAX_DW(ECD_MAX_DW)) pkt ();

   ecd_state_t state_q;
   logic [31:0] flHdr_q;
   logic [31:0] flDw1_q;
   logic [31:0] flLo_q;
   logic [31:0] flHi_q;
   logic flushActive_q;
   logic [31:0] hdr;
   logic [5:0] opcode;
   logic isControl;
   logic isFlush;
   logic isRegLoad;
   logic isNoop;
   logic isHead;
   logic isMbox;
   logic take;
   logic [1:0] flPost;
   logic flWrites;
   logic [3:0] bwd;

   ecd_dword_gatherer #(.MAX_DW(ECD_MAX_DW)) gatherer (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(cmdValid),
      .inData(cmdData),
      .inReady_q(cmdReady),
      .pkt(pkt.src)
   );

   // Header decode; only type and opcode steer, reserved bits are never looked at.
   assign hdr = pkt.dw[0];
   assign opcode = hdr[ECD_OP_HI:ECD_OP_LO];
   assign isControl = hdr[ECD_TYPE_HI:ECD_TYPE_LO] == ECD_TYPE_CONTROL;
   assign isFlush = isControl && opcode == ECD_OP_FLUSH;
   assign isRegLoad = isControl && opcode == ECD_OP_REG_LOAD;
   assign isNoop = isControl && opcode == ECD_OP_NOOP;
   assign isHead = isControl && opcode == ECD_OP_HEAD_REPORT;
   assign isMbox = isControl && opcode == ECD_OP_MAILBOX_SYNC;
   assign take = state_q == S_IDLE && pkt.valid;
   assign pkt.taken = take;
   assign bwd = hdr[ECD_LRI_BWD_HI:ECD_LRI_BWD_LO];

   // Only encodings 1h and 3h produce a write; 0h and the reserved 2h do not.
   assign flPost = flHdr_q[ECD_FL_POST_HI:ECD_FL_POST_LO];
   assign flWrites = flPost == ECD_POST_IMM || flPost == ECD_POST_TIME;

   // Sequencer: a flush waits for the engines, then writes, then posts its side effects.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         flushActive_q <= 1'b0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (take && isFlush) begin
                  state_q <= S_DRAIN;
                  flushActive_q <= 1'b1;
               end else if (take && isHead) begin
                  state_q <= S_MEMWR;
                  flushActive_q <= 1'b0;
               end
            end
            S_DRAIN: begin
               if (enginesIdle) begin
                  state_q <= flWrites ? S_MEMWR : S_POST;
               end
            end
            S_MEMWR: begin
               if (memWrAck) begin
                  state_q <= flushActive_q ? S_POST : S_IDLE;
               end
            end
            S_POST: begin
               state_q <= S_IDLE;
               flushActive_q <= 1'b0;
            end
         endcase
      end
   end

   // Captures the flush operands when the packet is taken.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flHdr_q <= 32'h00000000;
         flDw1_q <= 32'h00000000;
         flLo_q <= 32'h00000000;
         flHi_q <= 32'h00000000;
      end else if (take && isFlush) begin
         flHdr_q <= hdr;
         flDw1_q <= pkt.dw[1];
         flLo_q <= pkt.dw[2];
         flHi_q <= pkt.dw[3];
      end
   end

   // Memory write port: flush post-sync write and head report.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         memWrValid_q <= 1'b0;
         memWrAddr_q <= 32'h00000000;
         memWrData_q <= 64'h0000000000000000;
         memWrQword_q <= 1'b0;
         memWrGlobal_q <= 1'b0;
         memWrStatusIdx_q <= 1'b0;
         memWrPerProcPage_q <= 1'b0;
      end else if (state_q == S_DRAIN && enginesIdle && flWrites) begin
         memWrValid_q <= 1'b1;
         memWrAddr_q <= {flDw1_q[31:3], 3'h0};
         memWrQword_q <= 1'b1;
         memWrGlobal_q <= flDw1_q[ECD_FL_ADDR_GLOBAL];
         memWrStatusIdx_q <= flHdr_q[ECD_FL_STATUS_IDX];
         memWrPerProcPage_q <= flHdr_q[ECD_FL_STATUS_IDX] && inBatch && batchNonSecure && perProcessEnable;
         if (flPost == ECD_POST_TIME) begin
            memWrData_q <= {32'h00000000, elapsedTime};
         end else begin
            memWrData_q <= {flHi_q, flLo_q};
         end
      end else if (take && isHead) begin
         memWrValid_q <= 1'b1;
         memWrAddr_q <= headReportAddr;
         memWrData_q <= {32'h00000000, ringHead};
         memWrQword_q <= 1'b0;
         memWrGlobal_q <= 1'b1;
         memWrStatusIdx_q <= 1'b0;
         memWrPerProcPage_q <= 1'b0;
      end else if (memWrAck) begin
         memWrValid_q <= 1'b0;
      end
   end

   // Flush completion effects, one cycle each, after any write has been acknowledged.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tlbInvalidate_q <= 1'b0;
         taggedClear_q <= 1'b0;
         syncIrq_q <= 1'b0;
      end else begin
         tlbInvalidate_q <= state_q == S_POST &&
                            (!flushTlbModeSel || (flHdr_q[ECD_FL_TLB_INV] && flWrites));
         taggedClear_q <= state_q == S_POST && flHdr_q[ECD_FL_TAG_SYNC];
         syncIrq_q <= state_q == S_POST && flHdr_q[ECD_FL_NOTIFY] && !syncIrqMask;
      end
   end

   // Immediate register load: byte disables gate the write.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regWrValid_q <= 1'b0;
         regWrAddr_q <= 32'h00000000;
         regWrData_q <= 32'h00000000;
         regWrByteEn_q <= 4'h0;
      end else begin
         regWrValid_q <= take && isRegLoad && bwd != ECD_BWD_NONE;
         if (take && isRegLoad) begin
            regWrAddr_q <= {pkt.dw[1][31:2], 2'h0};
            regWrData_q <= pkt.dw[2];
            regWrByteEn_q <= ~bwd;
         end
      end
   end

   // No-op identification register, mailbox decode and unknown-command flag.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         noopId_q <= ECD_NOOP_ID_RST;
         mboxValid_q <= 1'b0;
         mboxSignal_q <= 1'b0;
         mboxWait_q <= 1'b0;
         badCmd_q <= 1'b0;
      end else begin
         if (take && isNoop && hdr[ECD_NOOP_ID_EN]) begin
            noopId_q <= hdr[ECD_NOOP_ID_W-1:0];
         end
         mboxValid_q <= take && isMbox;
         mboxSignal_q <= take && isMbox && hdr[ECD_MBOX_UPDATE] && !hdr[ECD_MBOX_COMPARE];
         mboxWait_q <= take && isMbox && hdr[ECD_MBOX_COMPARE];
         badCmd_q <= take && !(isFlush || isRegLoad || isNoop || isHead || isMbox);
      end
   end

   property p_flushWaitsIdle;
      @(posedge clk) disable iff (!rst_n)
      $rose(memWrValid_q) && flushActive_q |-> $past(enginesIdle);
   endproperty
   a_flushWaitsIdle: assert property (p_flushWaitsIdle) else $error("flush write before engines idle");

   property p_timeWrite;
      @(posedge clk) disable iff (!rst_n)
      state_q == S_DRAIN && enginesIdle && flPost == ECD_POST_TIME |=>
         memWrValid_q && memWrData_q == {32'h00000000, $past(elapsedTime)};
   endproperty
   a_timeWrite: assert property (p_timeWrite) else $error("elapsed time write wrong");

   property p_noWrite;
      @(posedge clk) disable iff (!rst_n)
      state_q == S_DRAIN && enginesIdle && !flWrites |=> !memWrValid_q ##1 state_q == S_IDLE;
   endproperty
   a_noWrite: assert property (p_noWrite) else $error("write issued for no-write flush");

   property p_immWrite;
      @(posedge clk) disable iff (!rst_n)
      state_q == S_DRAIN && enginesIdle && flPost == ECD_POST_IMM |=>
         memWrData_q == {flHi_q, flLo_q} && memWrAddr_q[2:0] == 3'h0 && memWrGlobal_q == flDw1_q[ECD_FL_ADDR_GLOBAL];
   endproperty
   a_immWrite: assert property (p_immWrite) else $error("immediate write wrong");

   property p_bwdSuppress;
      @(posedge clk) disable iff (!rst_n)
      take && isRegLoad && bwd == ECD_BWD_NONE |=> !regWrValid_q;
   endproperty
   a_bwdSuppress: assert property (p_bwdSuppress) else $error("register write not suppressed");

   property p_lriWrite;
      @(posedge clk) disable iff (!rst_n)
      take && isRegLoad && bwd == ECD_BWD_ALL |=>
         regWrValid_q && regWrByteEn_q == 4'hF && regWrAddr_q == {$past(pkt.dw[1][31:2]), 2'h0};
   endproperty
   a_lriWrite: assert property (p_lriWrite) else $error("register load write wrong");

   property p_noopId;
      @(posedge clk) disable iff (!rst_n)
      take && isNoop |=> noopId_q == ($past(hdr[ECD_NOOP_ID_EN]) ? $past(hdr[ECD_NOOP_ID_W-1:0]) : $past(noopId_q));
   endproperty
   a_noopId: assert property (p_noopId) else $error("identification register wrong");

   property p_tlbMode;
      @(posedge clk) disable iff (!rst_n)
      state_q == S_POST && !flushTlbModeSel |=> tlbInvalidate_q;
   endproperty
   a_tlbMode: assert property (p_tlbMode) else $error("missing invalidate in mode clear");

   property p_notify;
      @(posedge clk) disable iff (!rst_n)
      syncIrq_q |-> $past(state_q == S_POST) && !$past(syncIrqMask) && flHdr_q[ECD_FL_NOTIFY];
   endproperty
   a_notify: assert property (p_notify) else $error("spurious completion interrupt");

   property p_mbox;
      @(posedge clk) disable iff (!rst_n)
      take && isMbox |=> mboxValid_q && (mboxWait_q == $past(hdr[ECD_MBOX_COMPARE]));
   endproperty
   a_mbox: assert property (p_mbox) else $error("mailbox decode wrong");

   c_timeFlush: cover property (@(posedge clk) disable iff (!rst_n)
      state_q == S_DRAIN && flPost == ECD_POST_TIME ##[1:20] memWrAck);
   c_regLoad: cover property (@(posedge clk) disable iff (!rst_n) regWrValid_q);
   c_mbox: cover property (@(posedge clk) disable iff (!rst_n) mboxSignal_q);
   c_head: cover property (@(posedge clk) disable iff (!rst_n) take && isHead ##[1:20] memWrAck);
endmodule

//--- test/ecd_mem_model.sv
// Purpose: Memory side model that accepts the decoder's write requests.
// Assumes: A request is held by the decoder until it is acknowledged.
// Notes: The acknowledge delay is set by the bench to answer promptly or slowly.
module ecd_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic memWrValid,
   input wire logic [2:0] ackDelay,
   output logic memWrAck,
   output int wrCount
);
   timeunit 1ns;
   timeprecision 1ps;
   int waitCnt;

   // Counts the wait cycles, then gives a single acknowledge pulse per request.
   always @(posedge clk) begin
      if (!rst_n) begin
         memWrAck <= 1'b0;
         waitCnt <= 0;
         wrCount <= 0;
      end else begin
         memWrAck <= 1'b0;
         if (memWrValid && !memWrAck) begin
            if (waitCnt >= int'(ackDelay)) begin
               memWrAck <= 1'b1; // The request drops on the same edge at which this pulse is seen.
               waitCnt <= 0;
               wrCount <= wrCount + 1;
            end else begin
               waitCnt <= waitCnt + 1;
            end
         end
      end
   end
endmodule

//--- test/engine_control_command_decoder_test.sv
// Purpose: Self-checking bench for the engine control command decoder.
// Assumes: Commands are fed from the ring; writes are answered by the memory model.
// Notes: Random stimulus from a fixed seed, with corner cases mixed in.
module engine_control_command_decoder_test import ecd_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, cmdValid, cmdReady, inBatch, batchNonSecure, perProcessEnable;
   logic flushTlbModeSel, syncIrqMask, enginesIdle, memWr, memWrAck, memQw, memGl, memSi, memPp;
   logic regWr, mboxV, mboxSignal, mboxWait, tlbInv, tagClr, syncIrq, badCmd;
   logic [31:0] cmdData, elapsedTime, ringHead, headReportAddr, memWrAddr, regWrAddr, regWrData;
   logic [63:0] memWrData;
   logic [3:0] regWrByteEn;
   logic [ECD_NOOP_ID_W-1:0] noopId, expId;
   logic [2:0] ackDelay;
   logic sMem, sReg, sMbox, sBad, sTlb, sTag, sIrq, sEarly, sSig, sWait;
   logic [31:0] cAddr, cRegAddr, cRegData;
   logic [63:0] cData;
   logic [3:0] cBe, cFlags;
   int error_cnt = 0;
   int num_checks = 0;
   int wrCnt;

   ecd_cmd_decoder ecd_cmd_decoder_inst (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdData(cmdData),
      .cmdReady(cmdReady), .inBatch(inBatch), .batchNonSecure(batchNonSecure),
      .perProcessEnable(perProcessEnable), .flushTlbModeSel(flushTlbModeSel), .syncIrqMask(syncIrqMask),
      .enginesIdle(enginesIdle), .elapsedTime(elapsedTime), .ringHead(ringHead),
      .headReportAddr(headReportAddr), .memWrValid_q(memWr), .memWrAck(memWrAck), .memWrAddr_q(memWrAddr),
      .memWrData_q(memWrData), .memWrQword_q(memQw), .memWrGlobal_q(memGl), .memWrStatusIdx_q(memSi),
      .memWrPerProcPage_q(memPp), .regWrValid_q(regWr), .regWrAddr_q(regWrAddr), .regWrData_q(regWrData),
      .regWrByteEn_q(regWrByteEn), .noopId_q(noopId), .mboxValid_q(mboxV), .mboxSignal_q(mboxSignal),
      .mboxWait_q(mboxWait), .tlbInvalidate_q(tlbInv), .taggedClear_q(tagClr), .syncIrq_q(syncIrq),
      .badCmd_q(badCmd));
   ecd_mem_model ecd_mem_model_inst (.clk(clk), .rst_n(rst_n), .memWrValid(memWr), .ackDelay(ackDelay),
      .memWrAck(memWrAck), .wrCount(wrCnt));

   // The clock toggles every half period of a 100 MHz cycle.
   always #5 clk = ~clk;

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Offers each dword and holds it until an edge where ready is high.
   task automatic sendCmd(input logic [31:0] d[4], input int n);
      logic rdy;
      @(posedge clk);
      for (int k = 0; k < n; k++) begin
         cmdData <= d[k];
         cmdValid <= 1'b1;
         do begin
            @(negedge clk);
            rdy = cmdReady;
            @(posedge clk);
         end while (rdy !== 1'b1);
      end
      cmdValid <= 1'b0;
   endtask

   // Watches the outputs for a window; releases the engines after hold cycles.
   task automatic watch(input int hold);
      {sMem, sReg, sMbox, sBad, sTlb, sTag, sIrq, sEarly} = '0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (i == hold) enginesIdle <= 1'b1;
         @(negedge clk);
         if (i < hold && (memWr | tlbInv | tagClr | syncIrq) !== 1'b0) sEarly = 1'b1;
         if (memWr !== 1'b0 && !sMem) begin
            sMem = 1'b1;
            cAddr = memWrAddr;
            cData = memWrData;
            cFlags = {memQw, memGl, memSi, memPp};
         end
         if (regWr !== 1'b0) begin
            sReg = 1'b1;
            cRegAddr = regWrAddr;
            cRegData = regWrData;
            cBe = regWrByteEn;
         end
         if (mboxV !== 1'b0) begin
            sMbox = 1'b1;
            sSig = mboxSignal;
            sWait = mboxWait;
         end
         sBad |= badCmd;
         sTlb |= tlbInv;
         sTag |= tagClr;
         sIrq |= syncIrq;
      end
   endtask

   // Expected invalidate: every flush in clear mode, else the bit for post 1h or 3h.
   function automatic logic expTlb(input logic mode, input logic bit18, input logic [1:0] post);
      return !mode || (bit18 && (post == ECD_POST_IMM || post == ECD_POST_TIME));
   endfunction

   // Runs one flush with random control bits, context and engine stall.
   task automatic runFlush(input logic [1:0] post);
      logic [31:0] d[4];
      logic [31:0] r, et;
      logic b18, b17, b21, b8, mode, mask, ib, ns, pp, wr;
      int hold;
      r = $urandom;
      et = $urandom;
      {b18, b17, b21, b8, mode, mask, ib, ns, pp} = r[8:0];
      hold = 2 + int'(r[12:9] % 8);
      wr = (post == ECD_POST_IMM || post == ECD_POST_TIME);
      if (!wr) b17 = 1'b0;
      d[0] = {ECD_TYPE_CONTROL, ECD_OP_FLUSH, r[13], b21, 2'b00, b18, b17, 1'b0, post, r[18:14], b8, 2'b00, 6'h02};
      r = $urandom;
      d[1] = {r[31:3], r[0], 2'b00};
      d[2] = $urandom;
      d[3] = $urandom;
      @(posedge clk);
      {flushTlbModeSel, syncIrqMask, inBatch, batchNonSecure, perProcessEnable} <= {mode, mask, ib, ns, pp};
      enginesIdle <= 1'b0;
      elapsedTime <= et;
      ackDelay <= 3'($urandom % 6);
      sendCmd(d, 4);
      watch(hold);
      chk("flushEarly", 64'h0, {63'h0, sEarly});
      chk("flushWrite", {63'h0, wr}, {63'h0, sMem});
      if (wr) begin
         chk("flushAddr", {32'h0, d[1][31:3], 3'h0}, {32'h0, cAddr});
         chk("flushQword", 64'h1, {63'h0, cFlags[3]});
         chk("flushGlobal", {63'h0, r[0]}, {63'h0, cFlags[2]});
         chk("flushStatusIdx", {63'h0, b21}, {63'h0, cFlags[1]});
         chk("flushPerProc", {63'h0, b21 & ib & ns & pp}, {63'h0, cFlags[0]});
         chk("flushData", (post == ECD_POST_IMM) ? {d[3], d[2]} : {32'h0, et}, cData);
      end
      chk("flushTlb", {63'h0, expTlb(mode, b18, post)}, {63'h0, sTlb});
      chk("flushTagged", {63'h0, b17}, {63'h0, sTag});
      chk("flushIrq", {63'h0, b8 & !mask}, {63'h0, sIrq});
      chk("flushOther", 64'h0, {61'h0, sReg, sMbox, sBad});
   endtask

   // Main sequence: reset, then each command kind with corner and random cases.
   initial begin
      logic [31:0] d[4];
      logic [31:0] r;
      logic [3:0] bwd;
      clk = 1'b0;
      rst_n = 1'b0;
      {cmdValid, inBatch, batchNonSecure, perProcessEnable, flushTlbModeSel, syncIrqMask} = '0;
      enginesIdle = 1'b1;
      {cmdData, elapsedTime, ringHead, headReportAddr} = '0;
      ackDelay = 3'h0;
      expId = '0;
      void'($urandom(58));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("noopIdReset", 64'h0, {42'h0, noopId});
      // No-ops: all-ones identification, a disabled write, then random ones.
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 32'h007FFFFF : (i == 1) ? 32'h00155555 : $urandom;
         d[0] = {ECD_TYPE_CONTROL, ECD_OP_NOOP, r[22:0]};
         if (r[22]) expId = r[ECD_NOOP_ID_W-1:0];
         sendCmd(d, 1);
         watch(0);
         chk("noopId", {42'h0, expId}, {42'h0, noopId});
      end
      // Register loads with both defined disable codes, reserved bits random.
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         bwd = i[0] ? ECD_BWD_NONE : ECD_BWD_ALL;
         d[0] = {ECD_TYPE_CONTROL, ECD_OP_REG_LOAD, r[10:0], bwd, 8'h01};
         d[1] = {r[31:2], 2'b00};
         d[2] = $urandom;
         sendCmd(d, 3);
         watch(0);
         chk("regWrite", {63'h0, bwd != ECD_BWD_NONE}, {63'h0, sReg});
         if (bwd == ECD_BWD_ALL) begin
            chk("regAddr", {32'h0, d[1]}, {32'h0, cRegAddr});
            chk("regData", {32'h0, d[2]}, {32'h0, cRegData});
            chk("regByteEn", 64'hF, {60'h0, cBe});
         end
      end
      // Mailbox commands: signal, wait alone, wait with update.
      for (int i = 1; i < 4; i++) begin
         r = $urandom;
         d[0] = {ECD_TYPE_CONTROL, ECD_OP_MAILBOX_SYNC, 1'b0, i[0], i[1], 12'h000, 8'h01};
         d[1] = r;
         d[2] = {r[29:0], 2'b00};
         sendCmd(d, 3);
         watch(0);
         chk("mboxValid", 64'h1, {63'h0, sMbox});
         chk("mboxSignal", {63'h0, i == 1}, {63'h0, sSig});
         chk("mboxWait", {63'h0, i[1]}, {63'h0, sWait});
      end
      // Head report from the ring with a slow memory answer.
      r = $urandom;
      @(posedge clk);
      {ringHead, headReportAddr, inBatch, ackDelay} <= {r, $urandom & 32'hFFFFFFFC, 1'b0, 3'h5};
      d[0] = {ECD_TYPE_CONTROL, ECD_OP_HEAD_REPORT, 23'h000000};
      sendCmd(d, 1);
      watch(0);
      chk("headWrite", 64'h1, {63'h0, sMem});
      chk("headAddr", {32'h0, headReportAddr}, {32'h0, cAddr});
      chk("headData", {32'h0, r}, cData);
      chk("headFlags", 64'h4, {60'h0, cFlags});
      // Flushes cycling through every post-sync code.
      for (int i = 0; i < 16; i++) runFlush(2'(i));
      // A flush opcode under a non-control type is not a flush.
      d[0] = {3'h2, ECD_OP_FLUSH, 23'h00C002};
      sendCmd(d, 1);
      watch(0);
      chk("badType", 64'h1, {63'h0, sBad});
      chk("badTypeTlb", 64'h0, {63'h0, sTlb});
      // One head report plus eight flushes with post-sync 1h or 3h reach memory, each exactly once.
      chk("memWrites", 64'h9, 64'(wrCnt));
      final_report();
   end

   // Cuts a hang short well beyond the expected length of the run.
   initial begin
      #400000;
      error_cnt++;
      $display("unexpected run length: expected completion, seen timeout");
      final_report();
   end
endmodule
